// ==== design/scl_consts.svh ====
// Bit positions, latch codes and timing constants of the synthesizer control logic
`ifndef SCL_CONSTS_SVH
`define SCL_CONSTS_SVH
`define SCL_WORD_W 24
`define SCL_CODE_HI 1
`define SCL_CODE_LO 0
`define SCL_CODE_REF 2'h0
`define SCL_CODE_AB 2'h1
`define SCL_CODE_FUNC 2'h2
`define SCL_CODE_INIT 2'h3
`define SCL_BIT_CNT_RST 2
`define SCL_BIT_PD_ARM 3
`define SCL_MUX_HI 6
`define SCL_MUX_LO 4
`define SCL_BIT_PD_POL 7
`define SCL_BIT_CP_TRI 8
`define SCL_BIT_FL_EN 9
`define SCL_BIT_FL_MODE 10
`define SCL_TO_HI 14
`define SCL_TO_LO 11
`define SCL_CS1_HI 17
`define SCL_CS1_LO 15
`define SCL_CS2_HI 20
`define SCL_CS2_LO 18
`define SCL_BIT_PD_SYNC 21
`define SCL_PRE_HI 23
`define SCL_PRE_LO 22
`define SCL_BIT_GAIN 21
`define SCL_FUNC_RST 24'h000000
`define SCL_TO_W 8
`define SCL_TO_TABLE '{8'h03, 8'h07, 8'h0B, 8'h0F, 8'h13, 8'h17, 8'h1B, 8'h1F, \
   8'h23, 8'h27, 8'h2B, 8'h2F, 8'h33, 8'h37, 8'h3B, 8'h3F}
`endif

// ==== design/scl_fastlock_timer.sv ====
// Fastlock timeout counter counting charge pump events
`timescale 1ns/1ps
`default_nettype none
`include "scl_consts.svh"
module scl_fastlock_timer
   import scl_pkg::*;
#(
   parameter logic [`SCL_TO_W-1:0] TO_TABLE [16] = `SCL_TO_TABLE
)(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic run_in,
   input wire logic start_in,
   input wire logic tick_in,
   input wire logic [3:0] sel_in,
   output logic expire_out
);
   scl_timer_t t_reg;
   scl_timer_t t_next;

   always_comb begin
      t_next = t_reg;
      t_next.expire = 1'b0;
      if (!run_in) begin
         // Idle state whenever mode two is off, the part is down or the gain bit is neither set nor being set
         t_next.active = 1'b0;
         t_next.cnt = '0;
      end else if (start_in) begin
         t_next.active = 1'b1;
         t_next.cnt = TO_TABLE[sel_in]; // [R24]
      end else if (t_reg.active && tick_in) begin
         if (t_reg.cnt == '0) begin
            t_next.active = 1'b0;
            t_next.expire = 1'b1; // [R12]
         end else begin
            t_next.cnt = t_reg.cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         t_reg <= '0;
      end else begin
         t_reg <= t_next;
      end
   end

   assign expire_out = t_reg.expire;
endmodule
`default_nettype wire

// ==== design/scl_link_if.sv ====
// Carrier of the serial shift word from the link domain to the core
`timescale 1ns/1ps
`default_nettype none
`include "scl_consts.svh"
interface scl_link_if;
   logic [`SCL_WORD_W-1:0] shift_word;
   modport rx (output shift_word);
   modport core (input shift_word);
endinterface
`default_nettype wire

// ==== design/scl_pkg.sv ====
// Types shared by the synthesizer control logic
`include "scl_consts.svh"
package scl_pkg;
   typedef enum logic [1:0] {
      SCL_FL_OFF = 2'b00,
      SCL_FL_MODE1 = 2'b01,
      SCL_FL_MODE2 = 2'b10
   } scl_fl_state_t;

   typedef struct packed {
      logic le_s1;
      logic le_s2;
      logic le_s3;
      logic ce_s1;
      logic ce_s2;
      logic ev_s1;
      logic ev_s2;
      logic ev_s3;
      logic [`SCL_WORD_W-1:0] word_s1;
      logic [`SCL_WORD_W-1:0] word_s2;
      logic [`SCL_WORD_W-1:0] func;
      logic gain;
      logic init_armed;
      logic sync_pd;
      logic pulse;
      scl_fl_state_t fl;
      logic pd;
      logic hold;
      logic cp_tri;
      logic ld_rst;
      logic ref_buf_en;
      logic [2:0] cur;
      logic ref_load;
      logic ab_load;
   } scl_core_t;

   typedef struct packed {
      logic [`SCL_TO_W-1:0] cnt;
      logic active;
      logic expire;
   } scl_timer_t;
endpackage

// ==== design/scl_shift_rx.sv ====
// Serial input shift register running on the link clock
`timescale 1ns/1ps
`default_nettype none
`include "scl_consts.svh"
module scl_shift_rx
   import scl_pkg::*;
(
   input wire logic ser_clk_in,
   input wire logic ser_data_in,
   scl_link_if.rx link
);
   logic [`SCL_WORD_W-1:0] sh_reg;
   logic [`SCL_WORD_W-1:0] sh_next;

   // Msb first; keeps shifting during power-down [R23] [R08]
   always_comb begin
      sh_next = {sh_reg[`SCL_WORD_W-2:0], ser_data_in};
   end

   // Link clock stops between frames, so no reset is needed on pure data
   always_ff @(posedge ser_clk_in) begin
      sh_reg <= sh_next;
   end

   assign link.shift_word = sh_reg;
endmodule
`default_nettype wire

// ==== design/scl_top.sv ====
// Function and initialization control of the synthesizer, with its serial link
// Overview of operation
// R01 - Code 10 word loads function configuration
// R02 - Counter reset bit holds R, AB counters
// R03 - Released counters restart aligned together
// R04 - Chip enable low disables device at once
// R05 - Arm with sync-select 0 powers down now
// R06 - Arm with sync-select 1 waits pump event
// R07 - Power-down loads counters, tristates, resets detect
// R08 - Serial input keeps working during power-down
// R09 - Fastlock only when enable bit set
// R10 - Mode bit selects fastlock mode one/two
// R11 - Mode one: gain bit picks setting two
// R12 - Mode two: timeout clears gain bit
// R13 - Timeout counter runs only in mode two
// R14 - Setting one low field, two high field
// R15 - Host keeps prescaler output within limit
// R16 - Three-state bit floats charge pump output
// R17 - Code 11 loads function, fires reset pulse
// R18 - Init pulse also starts configured power-down
// R19 - First AB word after init refires pulse
// R20 - Host start-up through initialization word
// R21 - Host start-up through chip enable
// R22 - Counter reset tristates without sync power-down
// R23 - Msb-first 24-bit shift, load strobe transfers
// R24 - Timeout periods from parameter lookup table
`timescale 1ns/1ps
`default_nettype none
`include "scl_consts.svh"
module scl_top
   import scl_pkg::*;
(
   input wire logic CLK_IN,
   input wire logic SYS_RST_IN,
   input wire logic SER_CLK_IN,
   input wire logic SER_DATA_IN,
   input wire logic WORD_LOAD_STROBE_IN,
   input wire logic CHIP_ENABLE_IN,
   input wire logic CP_EVENT_IN,
   output logic POWERDOWN_OUT,
   output logic COUNTER_HOLD_OUT,
   output logic RESET_PULSE_OUT,
   output logic CP_TRISTATE_OUT,
   output logic [2:0] CP_CURRENT_OUT,
   output logic LOCK_DETECT_RST_OUT,
   output logic REF_BUF_EN_OUT,
   output logic [1:0] PRESCALER_SEL_OUT,
   output logic [2:0] MONITOR_MUX_SEL_OUT,
   output logic PD_POLARITY_OUT,
   output logic GAIN_BOOST_OUT,
   output logic [1:0] FASTLOCK_MODE_OUT,
   output logic REF_LOAD_OUT,
   output logic AB_LOAD_OUT
);
   scl_core_t r_reg;
   scl_core_t r_next;
   scl_link_if link ();
   logic expire;
   logic le_rise;
   logic ev_rise;
   logic timer_run;
   logic timer_start;

   function automatic logic code_is(input logic [`SCL_WORD_W-1:0] w, input logic [1:0] c);
      code_is = (w[`SCL_CODE_HI:`SCL_CODE_LO] == c);
   endfunction

   scl_shift_rx u_rx (
      .ser_clk_in(SER_CLK_IN),
      .ser_data_in(SER_DATA_IN),
      .link(link.rx)
   );

   scl_fastlock_timer u_timer (
      .clk_in(CLK_IN),
      .rst_in(SYS_RST_IN),
      .run_in(timer_run),
      .start_in(timer_start),
      .tick_in(ev_rise),
      .sel_in(r_reg.func[`SCL_TO_HI:`SCL_TO_LO]),
      .expire_out(expire)
   );

   assign le_rise = r_reg.le_s2 && !r_reg.le_s3;
   assign ev_rise = r_reg.ev_s2 && !r_reg.ev_s3;
   // Counter only in mode two and never while powered down [R13] [R07]
   // Start must count as run, since the gain bit only lands on the same edge
   assign timer_run = (r_reg.fl == SCL_FL_MODE2) && !r_reg.pd && (r_reg.gain || timer_start);
   assign timer_start = le_rise && code_is(r_reg.word_s2, `SCL_CODE_AB)
      && r_reg.word_s2[`SCL_BIT_GAIN];

   always_comb begin
      r_next = r_reg;
      // Pins from other domains pass two flops before logic looks at them, except chip enable, which power-down logic reads after ce_s1
      r_next.le_s1 = WORD_LOAD_STROBE_IN;
      r_next.le_s2 = r_reg.le_s1;
      r_next.le_s3 = r_reg.le_s2;
      r_next.ce_s1 = CHIP_ENABLE_IN;
      r_next.ce_s2 = r_reg.ce_s1;
      r_next.ev_s1 = CP_EVENT_IN;
      r_next.ev_s2 = r_reg.ev_s1;
      r_next.ev_s3 = r_reg.ev_s2;
      // Word is quiet while the strobe is high, so a two-flop bus copy is safe
      r_next.word_s1 = link.shift_word;
      r_next.word_s2 = r_reg.word_s1;
      r_next.pulse = 1'b0;
      r_next.ref_load = 1'b0;
      r_next.ab_load = 1'b0;

      // Expiry first so a fresh gain write in the same cycle wins
      if (expire) begin
         r_next.gain = 1'b0; // [R12]
      end

      // Transfers keep working in power-down [R08]
      if (le_rise) begin // [R23]
         case (r_reg.word_s2[`SCL_CODE_HI:`SCL_CODE_LO])
            `SCL_CODE_FUNC: begin
               r_next.func = r_reg.word_s2; // [R01]
            end
            `SCL_CODE_INIT: begin
               r_next.func = r_reg.word_s2; // [R17]
               r_next.pulse = 1'b1; // [R17]
               r_next.init_armed = 1'b1; // [R19]
            end
            `SCL_CODE_AB: begin
               r_next.gain = r_reg.word_s2[`SCL_BIT_GAIN]; // [R11]
               r_next.ab_load = 1'b1;
               if (r_reg.init_armed) begin
                  r_next.pulse = 1'b1; // [R19]
                  r_next.init_armed = 1'b0; // [R19]
               end
            end
            default: begin
               r_next.ref_load = 1'b1;
            end
         endcase
      end

      // Fastlock mode from enable and mode bits [R09] [R10]
      if (!r_next.func[`SCL_BIT_FL_EN]) begin
         r_next.fl = SCL_FL_OFF;
      end else if (r_next.func[`SCL_BIT_FL_MODE]) begin
         r_next.fl = SCL_FL_MODE2;
      end else begin
         r_next.fl = SCL_FL_MODE1;
      end

      // Synchronous power-down waits for a pump event to avoid frequency jumps
      if (!(r_next.func[`SCL_BIT_PD_ARM] && r_next.ce_s2)) begin
         r_next.sync_pd = 1'b0;
      end else if (r_next.func[`SCL_BIT_PD_SYNC] && ev_rise) begin
         r_next.sync_pd = 1'b1; // [R06]
      end else if (r_next.pulse && !r_next.func[`SCL_BIT_PD_SYNC]) begin
         r_next.sync_pd = 1'b1; // [R18]
      end

      // Chip enable overrides both power-down bits [R04] [R05]
      r_next.pd = !r_next.ce_s2 || r_next.sync_pd
         || (r_next.func[`SCL_BIT_PD_ARM] && !r_next.func[`SCL_BIT_PD_SYNC]);

      // One shared hold releases R and AB counters on the same edge [R02] [R03]
      r_next.hold = r_next.func[`SCL_BIT_CNT_RST] || r_next.pulse || r_next.pd; // [R07]
      // Counter reset floats the pump but leaves sync power-down alone [R22]
      r_next.cp_tri = r_next.func[`SCL_BIT_CP_TRI] || r_next.pd // [R16] [R07]
         || r_next.func[`SCL_BIT_CNT_RST] || r_next.pulse;
      r_next.ld_rst = r_next.pd; // [R07]
      r_next.ref_buf_en = !r_next.pd; // [R07]

      // Boosted current only with fastlock enabled and gain set [R14] [R11]
      if ((r_next.fl != SCL_FL_OFF) && r_next.gain) begin
         r_next.cur = r_next.func[`SCL_CS2_HI:`SCL_CS2_LO];
      end else begin
         r_next.cur = r_next.func[`SCL_CS1_HI:`SCL_CS1_LO];
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         r_reg <= '0;
         r_reg.func <= `SCL_FUNC_RST;
         r_reg.fl <= SCL_FL_OFF;
         r_reg.pd <= 1'b1;
         r_reg.hold <= 1'b1;
         r_reg.cp_tri <= 1'b1;
         r_reg.ld_rst <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // Prescaler value is passed as written; keeping it legal is the host's job
   assign POWERDOWN_OUT = r_reg.pd;
   assign COUNTER_HOLD_OUT = r_reg.hold;
   assign RESET_PULSE_OUT = r_reg.pulse;
   assign CP_TRISTATE_OUT = r_reg.cp_tri;
   assign CP_CURRENT_OUT = r_reg.cur;
   assign LOCK_DETECT_RST_OUT = r_reg.ld_rst;
   assign REF_BUF_EN_OUT = r_reg.ref_buf_en;
   assign PRESCALER_SEL_OUT = r_reg.func[`SCL_PRE_HI:`SCL_PRE_LO];
   assign MONITOR_MUX_SEL_OUT = r_reg.func[`SCL_MUX_HI:`SCL_MUX_LO];
   assign PD_POLARITY_OUT = r_reg.func[`SCL_BIT_PD_POL];
   assign GAIN_BOOST_OUT = r_reg.gain;
   assign FASTLOCK_MODE_OUT = r_reg.fl;
   assign REF_LOAD_OUT = r_reg.ref_load;
   assign AB_LOAD_OUT = r_reg.ab_load;

   route_func_a: assert property ( // [R01]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      le_rise && code_is(r_reg.word_s2, `SCL_CODE_FUNC) |=> r_reg.func == $past(r_reg.word_s2))
      else $error("function word not latched");

   cnt_hold_a: assert property ( // [R02]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      r_reg.func[`SCL_BIT_CNT_RST] |-> COUNTER_HOLD_OUT && CP_TRISTATE_OUT)
      else $error("counter reset bit not holding counters");

   ce_off_a: assert property ( // [R04]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      !r_reg.ce_s1 |=> POWERDOWN_OUT)
      else $error("chip enable low did not power down");

   async_pd_a: assert property ( // [R05]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      r_reg.func[`SCL_BIT_PD_ARM] && !r_reg.func[`SCL_BIT_PD_SYNC] |-> POWERDOWN_OUT)
      else $error("asynchronous power-down missing");

   sync_wait_a: assert property ( // [R06]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      $rose(r_reg.sync_pd) |-> $past(ev_rise) || $past(r_next.pulse))
      else $error("synchronous power-down without pump event");

   pd_effects_a: assert property ( // [R07]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      POWERDOWN_OUT |-> COUNTER_HOLD_OUT && CP_TRISTATE_OUT && LOCK_DETECT_RST_OUT
         && !REF_BUF_EN_OUT)
      else $error("power-down effects incomplete");

   tristate_bit_a: assert property ( // [R16]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      r_reg.func[`SCL_BIT_CP_TRI] |-> CP_TRISTATE_OUT)
      else $error("three-state bit ignored");

   init_pulse_a: assert property ( // [R17]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      le_rise && code_is(r_reg.word_s2, `SCL_CODE_INIT) |=> RESET_PULSE_OUT ##1 !RESET_PULSE_OUT)
      else $error("initialization pulse wrong");

   ab_once_a: assert property ( // [R19]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      le_rise && code_is(r_reg.word_s2, `SCL_CODE_AB) |=> RESET_PULSE_OUT == $past(r_reg.init_armed))
      else $error("AB word reset pulse wrong");

   cur_sel_a: assert property ( // [R14]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      !GAIN_BOOST_OUT |-> CP_CURRENT_OUT == r_reg.func[`SCL_CS1_HI:`SCL_CS1_LO])
      else $error("current setting one not selected");

   expire_clear_a: assert property ( // [R12]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      expire && !le_rise |=> !GAIN_BOOST_OUT)
      else $error("timeout did not clear gain bit");

   func_hold_a: assert property ( // [R01]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      !le_rise |=> $stable(r_reg.func))
      else $error("function word changed without a load");

   ce_on_a: assert property ( // [R04]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      r_reg.ce_s2 && !r_reg.func[`SCL_BIT_PD_ARM] |-> !POWERDOWN_OUT)
      else $error("enabled device not running");

   pd_gate_a: assert property ( // [R06]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      $rose(POWERDOWN_OUT) && r_reg.ce_s2 && r_reg.func[`SCL_BIT_PD_SYNC] |-> $past(ev_rise))
      else $error("synchronous power-down not gated by pump event");

   pd_keep_a: assert property ( // [R07]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      !POWERDOWN_OUT |-> REF_BUF_EN_OUT && !LOCK_DETECT_RST_OUT)
      else $error("power-down effects while running");

   ref_pd_a: assert property ( // [R08]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      le_rise && POWERDOWN_OUT && code_is(r_reg.word_s2, `SCL_CODE_REF) |=> REF_LOAD_OUT)
      else $error("word lost during power-down");

   fl_off_a: assert property ( // [R09]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      !r_reg.func[`SCL_BIT_FL_EN] |-> FASTLOCK_MODE_OUT == SCL_FL_OFF)
      else $error("fastlock active while disabled");

   fl_mode_a: assert property ( // [R10]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      r_reg.func[`SCL_BIT_FL_EN] |->
         FASTLOCK_MODE_OUT == (r_reg.func[`SCL_BIT_FL_MODE] ? SCL_FL_MODE2 : SCL_FL_MODE1))
      else $error("fastlock mode not selected by mode bit");

   boost_cur_a: assert property ( // [R11]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      GAIN_BOOST_OUT && (r_reg.fl != SCL_FL_OFF) |->
         CP_CURRENT_OUT == r_reg.func[`SCL_CS2_HI:`SCL_CS2_LO])
      else $error("current setting two not selected");

   ab_gain_a: assert property ( // [R11]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      le_rise && code_is(r_reg.word_s2, `SCL_CODE_AB) |=>
         GAIN_BOOST_OUT == $past(r_reg.word_s2[`SCL_BIT_GAIN]))
      else $error("gain bit not taken from AB word");

   gain_hold_a: assert property ( // [R12]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      !le_rise && !expire |=> $stable(GAIN_BOOST_OUT))
      else $error("gain bit changed without write or timeout");

   timer_idle_a: assert property ( // [R13]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      r_reg.fl != SCL_FL_MODE2 |=> !expire)
      else $error("timeout counter ran outside mode two");

   init_arm_a: assert property ( // [R19]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      le_rise && code_is(r_reg.word_s2, `SCL_CODE_INIT) |=> r_reg.init_armed)
      else $error("initialization did not arm AB pulse");

   pulse_hold_a: assert property ( // [R17]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      RESET_PULSE_OUT |-> COUNTER_HOLD_OUT && CP_TRISTATE_OUT)
      else $error("reset pulse did not load counters");

   init_pd_a: assert property ( // [R18]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      le_rise && code_is(r_reg.word_s2, `SCL_CODE_INIT) && r_reg.word_s2[`SCL_BIT_PD_ARM]
         && !r_reg.word_s2[`SCL_BIT_PD_SYNC] |=> POWERDOWN_OUT)
      else $error("initialization did not start power-down");

   crst_nopd_a: assert property ( // [R22]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      r_reg.func[`SCL_BIT_CNT_RST] && !r_reg.func[`SCL_BIT_PD_ARM] |-> !r_reg.sync_pd)
      else $error("counter reset started power-down");

   ref_pulse_a: assert property ( // [R23]
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      le_rise && code_is(r_reg.word_s2, `SCL_CODE_REF) |=> REF_LOAD_OUT ##1 !REF_LOAD_OUT)
      else $error("reference load pulse wrong");
endmodule
`default_nettype wire

// ==== testbench/scl_host_model.sv ====
// Host side of the serial link: shifts words out and strobes them in
`timescale 1ns/1ps
`default_nettype none
`include "scl_consts.svh"
module scl_host_model (
   output logic ser_clk_out,
   output logic ser_data_out,
   output logic le_out
);
   // Link clock stands still outside frames, 64 ns period inside them
   initial begin
      ser_clk_out = 1'b0;
      ser_data_out = 1'b1;
      le_out = 1'b0;
   end

   task automatic send(input logic [`SCL_WORD_W-1:0] word);
      for (int i = `SCL_WORD_W - 1; i >= 0; i--) begin
         ser_data_out = word[i];
         #32 ser_clk_out = 1'b1;
         #32 ser_clk_out = 1'b0;
      end
      // Released data line shows the inverse, not a stale bit
      ser_data_out = ~word[0];
      #32 le_out = 1'b1;
      // Strobe held and released well beyond three system cycles
      #64 le_out = 1'b0;
      #64;
   endtask
endmodule
`default_nettype wire

// ==== testbench/scl_top_tb_top.sv ====
// Self-checking bench for the synthesizer control logic
`timescale 1ns/1ps
`default_nettype none
`include "scl_consts.svh"
module scl_top_tb_top;
   import scl_pkg::*;
   // Prescaler 2'h2 keeps the divided output in range for the assumed input
   localparam logic [23:0] BASE = 24'h9980D2;
   localparam logic [23:0] TRI = 24'h000100;
   localparam logic [23:0] CRST = 24'h000004;
   localparam logic [23:0] ARM = 24'h000008;
   localparam logic [23:0] SYNC = 24'h200000;
   localparam logic [23:0] FEN = 24'h000200;
   localparam logic [23:0] FMODE = 24'h000400;
   localparam logic [23:0] TO1 = 24'h000800;
   localparam logic [23:0] AB0 = 24'h001235;
   localparam logic [23:0] ABG = 24'h201235;
   localparam logic [23:0] REFW = 24'h000028;
   logic clk, rst, ser_clk, ser_data, le, ce, cp_ev;
   logic pd, hold, rp, tri_s, ldr, rbuf, pol, gain, refl, abl;
   logic [2:0] cur, mux;
   logic [1:0] pre, flm;
   int n_mismatch = 0;
   int n_tests = 0;
   int n_cyc = 0;
   int n_rp = 0, n_ab = 0, n_rf = 0, s_rp = 0, s_ab = 0, s_rf = 0;

   scl_host_model i_scl_host_model (.ser_clk_out(ser_clk), .ser_data_out(ser_data),
      .le_out(le));
   scl_top i_scl_top (.CLK_IN(clk), .SYS_RST_IN(rst), .SER_CLK_IN(ser_clk),
      .SER_DATA_IN(ser_data), .WORD_LOAD_STROBE_IN(le), .CHIP_ENABLE_IN(ce),
      .CP_EVENT_IN(cp_ev), .POWERDOWN_OUT(pd), .COUNTER_HOLD_OUT(hold),
      .RESET_PULSE_OUT(rp), .CP_TRISTATE_OUT(tri_s), .CP_CURRENT_OUT(cur),
      .LOCK_DETECT_RST_OUT(ldr), .REF_BUF_EN_OUT(rbuf), .PRESCALER_SEL_OUT(pre),
      .MONITOR_MUX_SEL_OUT(mux), .PD_POLARITY_OUT(pol), .GAIN_BOOST_OUT(gain),
      .FASTLOCK_MODE_OUT(flm), .REF_LOAD_OUT(refl), .AB_LOAD_OUT(abl));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Pulses are counted mid-cycle, clear of the edge that launches them
   always @(negedge clk) begin
      n_rp += (rp === 1'b1);
      n_ab += (abl === 1'b1);
      n_rf += (refl === 1'b1);
      n_cyc++;
      // About 24 words of 345 cycles each fit well inside this ceiling
      if (n_cyc == 40000) begin
         n_mismatch++;
         $display("BAD t=%0t timeout", $time);
         conclude();
      end
   end

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [2:0] got, input logic [2:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got %b exp %b", $time, got, exp);
      end
   endtask

   task automatic pulses(input int erp, input int eab, input int erf);
      n_tests++;
      if (n_rp - s_rp != erp || n_ab - s_ab != eab || n_rf - s_rf != erf) begin
         n_mismatch++;
         $display("BAD t=%0t pulse counts %0d %0d %0d", $time, n_rp - s_rp,
            n_ab - s_ab, n_rf - s_rf);
      end
      s_rp = n_rp;
      s_ab = n_ab;
      s_rf = n_rf;
   endtask

   task automatic wr(input logic [23:0] w);
      i_scl_host_model.send(w);
      repeat (4) @(negedge clk);
   endtask

   task automatic ev(input int n);
      repeat (n) begin
         @(negedge clk);
         cp_ev = 1'b1;
         repeat (3) @(negedge clk);
         cp_ev = 1'b0;
         repeat (3) @(negedge clk);
      end
      repeat (4) @(negedge clk);
   endtask

   task automatic done(input string name);
      $display("test %s finished", name);
   endtask

   initial begin
      rst = 1'b1;
      ce = 1'b1;
      cp_ev = 1'b0;
      // Synchroniser flops clear with the rest of the state
      repeat (2) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      wr(BASE);
      chk(pre, 3'h2);
      chk(mux, 3'h5);
      chk(pol, 3'h1);
      chk(cur, 3'h3);
      chk(hold, 3'h0);
      chk(flm, 3'h0);
      done("fields");
      wr(BASE | TRI);
      chk(tri_s, 3'h1);
      wr(BASE);
      chk(tri_s, 3'h0);
      done("tristate");
      wr(BASE | CRST | SYNC);
      chk(hold, 3'h1);
      chk(tri_s, 3'h1);
      ev(2);
      chk(pd, 3'h0);
      wr(BASE);
      chk(hold, 3'h0);
      done("counter_reset");
      @(negedge clk);
      ce = 1'b0;
      repeat (4) @(negedge clk);
      chk(pd, 3'h1);
      chk({hold, tri_s, ldr}, 3'h7);
      chk(rbuf, 3'h0);
      wr(BASE ^ 24'h000060);
      chk(mux, 3'h3);
      ce = 1'b1;
      repeat (4) @(negedge clk);
      chk({pd, hold, rbuf}, 3'h1);
      wr(BASE);
      done("chip_enable");
      wr(BASE | ARM);
      chk(pd, 3'h1);
      wr(BASE);
      chk(pd, 3'h0);
      wr(BASE | ARM | SYNC);
      chk(pd, 3'h0);
      ev(1);
      chk(pd, 3'h1);
      wr(BASE);
      done("power_down");
      wr(ABG);
      chk(cur, 3'h3);
      wr(BASE | FEN);
      chk(flm, 3'h1);
      wr(AB0);
      chk(cur, 3'h3);
      wr(ABG);
      chk({gain, flm}, 3'h5);
      chk(cur, 3'h6);
      ev(8);
      chk(gain, 3'h1);
      wr(AB0);
      chk(cur, 3'h3);
      done("fastlock_one");
      wr(BASE | FEN | FMODE | TO1);
      chk(flm, 3'h2);
      wr(ABG);
      chk(cur, 3'h6);
      ev(7);
      chk(gain, 3'h1);
      ev(1);
      chk(gain, 3'h0);
      chk(cur, 3'h3);
      done("fastlock_two");
      pulses(0, 5, 0);
      wr(BASE | 24'h000001);
      pulses(1, 0, 0);
      chk(mux, 3'h5);
      wr(BASE);
      wr(REFW);
      pulses(0, 0, 1);
      wr(AB0);
      pulses(1, 1, 0);
      wr(AB0);
      pulses(0, 1, 0);
      wr(BASE | 24'h000001 | ARM);
      chk(pd, 3'h1);
      pulses(1, 0, 0);
      done("initialization");
      conclude();
   end
endmodule
`default_nettype wire
